//--- core/flsr_pkg.sv
// constants and carrier types for the fault latch status register bank
package flsr_pkg;

   // register addresses
   localparam logic [7:0] FLSR_ADDR_CH2_FAULT   = 8'h37;
   localparam logic [7:0] FLSR_ADDR_ADC_MASK    = 8'h38;
   localparam logic [7:0] FLSR_ADDR_REG_SHORT   = 8'h39;
   localparam logic [7:0] FLSR_ADDR_EVENT_ONE   = 8'h3A;

   // reset values
   localparam logic [7:0] FLSR_RST_CH2_FAULT    = 8'h00;
   localparam logic [7:0] FLSR_RST_ADC_MASK     = 8'h00;
   localparam logic [7:0] FLSR_RST_REG_SHORT    = 8'h00;
   localparam logic [7:0] FLSR_RST_EVENT_ONE    = 8'h00;

   // field positions, ch2 input fault latch
   localparam int FLSR_CH2_OPEN_BIT      = 7;
   localparam int FLSR_CH2_SHORTED_BIT   = 6;
   localparam int FLSR_CH2_POS_GND_BIT   = 5;
   localparam int FLSR_CH2_NEG_GND_BIT   = 4;
   localparam int FLSR_CH2_POS_BIAS_BIT  = 3;
   localparam int FLSR_CH2_NEG_BIAS_BIT  = 2;
   localparam int FLSR_CH2_POS_BAT_BIT   = 1;
   localparam int FLSR_CH2_NEG_BAT_BIT   = 0;

   // field positions, adc overload mask
   localparam int FLSR_CH1_OVL_MASK_BIT  = 3;
   localparam int FLSR_CH2_OVL_MASK_BIT  = 2;

   // field positions, regulator short latch and mask
   localparam int FLSR_REG_SHORT_MASK_BIT = 1;
   localparam int FLSR_REG_SHORT_LTCH_BIT = 0;

   // field positions, latched event register one
   localparam int FLSR_EV_CH1_POS_OV_BIT = 7;
   localparam int FLSR_EV_CH1_NEG_OV_BIT = 6;
   localparam int FLSR_EV_CH2_POS_OV_BIT = 5;
   localparam int FLSR_EV_CH2_NEG_OV_BIT = 4;
   localparam int FLSR_EV_INSERT_BIT     = 3;
   localparam int FLSR_EV_REMOVE_BIT     = 2;
   localparam int FLSR_EV_HOOK_BIT       = 1;
   localparam int FLSR_EV_LOAD_BIT       = 0;

   // writable bits per register
   localparam logic [7:0] FLSR_WMASK_ADC_MASK  = 8'h0C;
   localparam logic [7:0] FLSR_WMASK_REG_SHORT = 8'h02;

   // control port request from the host interface logic
   typedef struct packed {
      logic       rd;     // one-cycle read strobe
      logic       wr;     // one-cycle write strobe
      logic [7:0] addr;   // register address
      logic [7:0] wdata;  // write data
   } flsr_req_s;

   // fault and event detector pulses or levels
   typedef struct packed {
      logic [7:0] ch2_fault;   // ch2 input fault conditions, bit per field
      logic       reg_short;   // analog regulator short circuit
      logic [7:0] event_one;   // over-voltage, headset and load events
   } flsr_det_s;

   // mask bits steering the fault reporting logic
   typedef struct packed {
      logic ch1_adc_overload_mask;
      logic ch2_adc_overload_mask;
      logic regulator_short_mask;
   } flsr_mask_s;

endpackage : flsr_pkg

//--- core/flsr_sync.sv
// two-flop synchroniser bank for asynchronous detector levels
`timescale 1ns/1ps
`default_nettype none
module flsr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,    // control clock
   input  wire logic             rst_in,    // async reset, active high
   input  wire logic [WIDTH-1:0] async_in,  // raw levels from analog side
   output logic      [WIDTH-1:0] sync_out   // levels in clock domain
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } flsr_sync_s;

   flsr_sync_s state_reg;
   flsr_sync_s state_next;

   // first stage feeds only the second stage
   always_comb begin
      state_next        = state_reg;
      state_next.meta   = async_in;
      state_next.stable = state_reg.meta;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stable;

endmodule : flsr_sync
`default_nettype wire

//--- core/flsr_regs.sv
// fault latch status register bank with mask bits
// Functional notes
// - bit 7 of ch2 fault latch records open inputs, cleared by read.
// - bit 6 records the two ch2 inputs shorted together.
// - bits 5 and 4 record ch2 positive and negative shorts to ground.
// - bits 3 and 2 record ch2 input shorts to mic bias supply.
// - bits 1 and 0 record ch2 input shorts to battery sense.
// - ch2 fault latch sits at 0x37, read-only, resets to 0x00.
// - bit 3 of 0x38 masks ch1 adc overload, read-write, reset 0.
// - bit 2 of 0x38 masks ch2 adc overload, read-write, reset 0.
// - 0x39 bit 0 latches regulator short, bit 1 masks it.
// - 0x3A bits 7..4 latch ch1/ch2 input over-voltage events.
// - 0x3A bit 3 latches headset insertion.
// - 0x3A bit 2 latches headset removal.
// - 0x3A bit 1 latches headset hook button.
// - 0x3A bit 0 latches processing overload.
// - channel summary ch2 position is set when any ch2 fault latched.
`timescale 1ns/1ps
`default_nettype none
module flsr_regs (
   input  wire logic                clk_in,        // 200 MHz control clock
   input  wire logic                rst_in,        // async reset, high
   input  wire flsr_pkg::flsr_req_s req_in,        // host register access
   input  wire flsr_pkg::flsr_det_s det_in,        // raw detector levels
   output logic [7:0]               rdata_out,     // read data, registered
   output logic                     rvalid_out,    // read data valid pulse
   output flsr_pkg::flsr_mask_s     mask_out,      // mask bits to fault logic
   output logic                     ch2_summary_out, // ch2 any-fault latched
   output logic                     reg_short_flag_out // unmasked short
);
   import flsr_pkg::*;

   localparam int DET_W = 17;

   typedef struct packed {
      logic [7:0] ch2_fault;
      logic       ch1_ovl_mask;
      logic       ch2_ovl_mask;
      logic       reg_short_mask;
      logic       reg_short_ltch;
      logic [7:0] event_one;
      logic [7:0] rdata;
      logic       rvalid;
   } flsr_state_s;

   flsr_state_s state_reg;
   flsr_state_s state_next;

   logic [DET_W-1:0] det_raw;
   logic [DET_W-1:0] det_sync;
   logic [7:0]       ch2_det;
   logic             short_det;
   logic [7:0]       event_det;

   // detectors live in the analog domain, so bring them in first
   assign det_raw = {det_in.ch2_fault, det_in.reg_short, det_in.event_one};

   flsr_sync #(
      .WIDTH (DET_W)
   ) u_det_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .async_in (det_raw),
      .sync_out (det_sync)
   );

   assign ch2_det   = det_sync[16:9];
   assign short_det = det_sync[8];
   assign event_det = det_sync[7:0];

   // register address match, used for reads and writes alike
   function automatic logic hit(input flsr_req_s r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction : hit

   // assemble the read image; reserved bits stay zero
   function automatic logic [7:0] read_image(input flsr_state_s s,
                                             input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         FLSR_ADDR_CH2_FAULT: v = s.ch2_fault;
         FLSR_ADDR_ADC_MASK: begin
            v[FLSR_CH1_OVL_MASK_BIT] = s.ch1_ovl_mask;
            v[FLSR_CH2_OVL_MASK_BIT] = s.ch2_ovl_mask;
         end
         FLSR_ADDR_REG_SHORT: begin
            v[FLSR_REG_SHORT_MASK_BIT] = s.reg_short_mask;
            v[FLSR_REG_SHORT_LTCH_BIT] = s.reg_short_ltch;
         end
         FLSR_ADDR_EVENT_ONE: v = s.event_one;
         default: v = 8'h00;
      endcase
      read_image = v;
   endfunction : read_image

   // latch updates: a read clears, but a fresh detection wins over it
   always_comb begin
      logic rd_ch2;
      logic rd_short;
      logic rd_event;
      rd_ch2   = req_in.rd && hit(req_in, FLSR_ADDR_CH2_FAULT);
      rd_short = req_in.rd && hit(req_in, FLSR_ADDR_REG_SHORT);
      rd_event = req_in.rd && hit(req_in, FLSR_ADDR_EVENT_ONE);
      state_next = state_reg;

      // read data answers one cycle after the strobe
      state_next.rvalid = req_in.rd;
      state_next.rdata  = req_in.rd ? read_image(state_reg, req_in.addr)
                                    : state_reg.rdata;

      // ch2 input faults, bits 7 down to 0
      state_next.ch2_fault = (rd_ch2 ? 8'h00 : state_reg.ch2_fault)
                             | ch2_det;

      // regulator short latch is read-only, only the read clears it
      state_next.reg_short_ltch = (rd_short ? 1'b0
                                            : state_reg.reg_short_ltch)
                                  | short_det;

      // over-voltage, headset and processing load events
      state_next.event_one = (rd_event ? 8'h00 : state_reg.event_one)
                             | event_det;

      // writes reach only the mask bits; reserved and latch bits ignore
      if (req_in.wr && hit(req_in, FLSR_ADDR_ADC_MASK)) begin
         state_next.ch1_ovl_mask = req_in.wdata[FLSR_CH1_OVL_MASK_BIT];
         state_next.ch2_ovl_mask = req_in.wdata[FLSR_CH2_OVL_MASK_BIT];
      end
      if (req_in.wr && hit(req_in, FLSR_ADDR_REG_SHORT)) begin
         state_next.reg_short_mask =
            req_in.wdata[FLSR_REG_SHORT_MASK_BIT];
      end
   end

   // all state resets to the documented register defaults
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg.ch2_fault      <= FLSR_RST_CH2_FAULT;
         state_reg.ch1_ovl_mask   <= FLSR_RST_ADC_MASK[FLSR_CH1_OVL_MASK_BIT];
         state_reg.ch2_ovl_mask   <= FLSR_RST_ADC_MASK[FLSR_CH2_OVL_MASK_BIT];
         state_reg.reg_short_mask <=
            FLSR_RST_REG_SHORT[FLSR_REG_SHORT_MASK_BIT];
         state_reg.reg_short_ltch <=
            FLSR_RST_REG_SHORT[FLSR_REG_SHORT_LTCH_BIT];
         state_reg.event_one      <= FLSR_RST_EVENT_ONE;
         state_reg.rdata          <= 8'h00;
         state_reg.rvalid         <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_out  = state_reg.rdata;
   assign rvalid_out = state_reg.rvalid;

   // masks steer the downstream fault reporting
   assign mask_out.ch1_adc_overload_mask = state_reg.ch1_ovl_mask;
   assign mask_out.ch2_adc_overload_mask = state_reg.ch2_ovl_mask;
   assign mask_out.regulator_short_mask  = state_reg.reg_short_mask;

   // summary follows the latched bits so it clears with them
   assign ch2_summary_out = |state_reg.ch2_fault;

   // a masked short is still latched but not flagged onward
   assign reg_short_flag_out = state_reg.reg_short_ltch
                               & ~state_reg.reg_short_mask;

endmodule : flsr_regs
`default_nettype wire

//--- test/flsr_regs_properties.sv
// assertion checker for the fault latch status register bank
`timescale 1ns/1ps
`default_nettype none
module flsr_regs_properties (
   input wire logic                clk_in,            // control clock
   input wire logic                rst_in,            // async reset
   input wire flsr_pkg::flsr_req_s req_in,            // host access
   input wire flsr_pkg::flsr_det_s det_in,            // detector levels
   input wire logic [7:0]          rdata_out,         // read data
   input wire logic                rvalid_out,        // read valid
   input wire flsr_pkg::flsr_mask_s mask_out,         // mask bits
   input wire logic                ch2_summary_out,   // ch2 summary
   input wire logic                reg_short_flag_out // unmasked short
);
   import flsr_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // detection opening a four-cycle read-free stretch, so nothing clears it early
   sequence s_ch2_hit;
      (|det_in.ch2_fault) ##0 (!req_in.rd) [*4];
   endsequence
   sequence s_short_hit;
      det_in.reg_short ##0 (!req_in.rd) [*4];
   endsequence

   a_read_answers: assert property (req_in.rd |=> rvalid_out)
      else $error("read not answered");
   a_no_stray_valid: assert property (!req_in.rd |=> !rvalid_out)
      else $error("valid without read");
   a_unmapped_zero: assert property (req_in.rd &&
      (req_in.addr < 8'h37 || req_in.addr > 8'h3A) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_adc_mask_write: assert property (req_in.wr && req_in.addr == 8'h38
      |=> {mask_out.ch1_adc_overload_mask, mask_out.ch2_adc_overload_mask}
      == $past(req_in.wdata[3:2])) else $error("adc mask write lost");
   a_mask_hold: assert property (!req_in.wr |=> $stable(mask_out))
      else $error("mask moved without write");
   a_adc_mask_read: assert property (req_in.rd && !req_in.wr &&
      req_in.addr == 8'h38 |=> rdata_out == {4'h0,
      $past(mask_out.ch1_adc_overload_mask),
      $past(mask_out.ch2_adc_overload_mask), 2'h0})
      else $error("adc mask readback wrong");
   a_short_reg_read: assert property (req_in.rd && !req_in.wr &&
      req_in.addr == 8'h39 |=> rdata_out[7:1] ==
      {6'h00, $past(mask_out.regulator_short_mask)})
      else $error("short register readback wrong");
   a_flag_masked: assert property (mask_out.regulator_short_mask
      |-> !reg_short_flag_out) else $error("masked short flagged");
   a_short_seen: assert property (s_short_hit |->
      reg_short_flag_out == !mask_out.regulator_short_mask)
      else $error("short not latched");
   a_summary_sets: assert property (s_ch2_hit |-> ch2_summary_out)
      else $error("summary missed fault");
   a_summary_holds: assert property (ch2_summary_out &&
      !(req_in.rd && req_in.addr == 8'h37) |=> ch2_summary_out)
      else $error("summary dropped without read");
endmodule : flsr_regs_properties
bind flsr_regs flsr_regs_properties u_props (.clk_in, .rst_in, .req_in,
   .det_in, .rdata_out, .rvalid_out, .mask_out, .ch2_summary_out,
   .reg_short_flag_out);
`default_nettype wire

//--- test/flsr_regs_tb.sv
// self-checking bench for the fault latch status register bank
`timescale 1ns/1ps
`default_nettype none
module flsr_regs_tb;
   import flsr_pkg::*;
   logic       clk_in;
   logic       rst_in;
   flsr_req_s  req;
   flsr_det_s  det;
   flsr_det_s  d;
   flsr_mask_s mask;
   logic [7:0] rdata;
   logic       rvalid;
   logic       summary;
   logic       flag;
   int         num_errors;
   int         total_checks;
   int         cycles;

   flsr_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
      .det_in(det), .rdata_out(rdata), .rvalid_out(rvalid),
      .mask_out(mask), .ch2_summary_out(summary),
      .reg_short_flag_out(flag));

   // 200 MHz control clock
   initial begin
      clk_in = 1'h0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic stop_test;
      $display("num_errors %0d total_checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // read strobe; the valid pulse lasts one cycle, so look right then
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      req.rd = 1'h1;
      req.addr = a;
      @(negedge clk_in);
      req.rd = 1'h0;
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
      @(negedge clk_in);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req.wr = 1'h1;
      req.addr = a;
      req.wdata = v;
      @(negedge clk_in);
      req.wr = 1'h0;
      @(negedge clk_in);
   endtask : wr

   // one-cycle detector pulse, then room for the two-flop sync
   task automatic pulse(input flsr_det_s p);
      det = p;
      @(negedge clk_in);
      det = '0;
      repeat (4) @(negedge clk_in);
   endtask : pulse

   task automatic t_reset;
      chk({5'h00, mask}, 8'h00);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'h00);
      rd(8'h39, 8'h00);
      rd(8'h3A, 8'h00);
   endtask : t_reset

   // writable bits only; read-only and unmapped places stay zero
   task automatic t_masks;
      wr(8'h38, 8'h0C);
      chk({5'h00, mask}, 8'h06);
      rd(8'h38, 8'h0C);
      wr(8'h38, 8'h08);
      rd(8'h38, 8'h08);
      wr(8'h38, 8'h04);
      rd(8'h38, 8'h04);
      wr(8'h38, 8'h00);
      wr(8'h37, 8'hFF);
      rd(8'h37, 8'h00);
      wr(8'h3A, 8'hFF);
      rd(8'h3A, 8'h00);
      rd(8'h40, 8'h00);
      rd(8'h36, 8'h00);
   endtask : t_masks

   task automatic t_ch2;
      for (int i = 0; i < 8; i++) begin
         d = '0;
         d.ch2_fault = 8'h01 << i;
         pulse(d);
         repeat (6) @(negedge clk_in);
         chk({7'h00, summary}, 8'h01);
         rd(8'h3A, 8'h00);
         rd(8'h37, 8'h01 << i);
         rd(8'h37, 8'h00);
         chk({7'h00, summary}, 8'h00);
      end
   endtask : t_ch2

   task automatic t_events;
      for (int i = 0; i < 8; i++) begin
         d = '0;
         d.event_one = 8'h01 << i;
         pulse(d);
         rd(8'h37, 8'h00);
         rd(8'h3A, 8'h01 << i);
         rd(8'h3A, 8'h00);
      end
   endtask : t_events

   task automatic t_short;
      d = '0;
      d.reg_short = 1'h1;
      pulse(d);
      chk({7'h00, flag}, 8'h01);
      rd(8'h39, 8'h01);
      rd(8'h39, 8'h00);
      wr(8'h39, 8'h02);
      chk({5'h00, mask}, 8'h01);
      pulse(d);
      chk({7'h00, flag}, 8'h00);
      rd(8'h39, 8'h03);
      wr(8'h39, 8'h00);
   endtask : t_short

   // a held level re-sets the latch through a read; mid-run reset clears all
   task automatic t_hold_reset;
      d = '0;
      d.ch2_fault = 8'h80;
      det = d;
      repeat (3) @(negedge clk_in);
      rd(8'h37, 8'h80);
      rd(8'h37, 8'h80);
      det = '0;
      repeat (3) @(negedge clk_in);
      rd(8'h37, 8'h80);
      rd(8'h37, 8'h00);
      wr(8'h38, 8'h0C);
      pulse(d);
      rst_in = 1'h1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'h0;
      @(negedge clk_in);
      chk({5'h00, mask}, 8'h00);
      chk({7'h00, summary}, 8'h00);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'h00);
   endtask : t_hold_reset

   initial begin
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      rst_in = 1'h1;
      req = '0;
      det = '0;
      repeat (5) @(negedge clk_in);
      rst_in = 1'h0;
      @(negedge clk_in);
      t_reset();
      t_masks();
      t_ch2();
      t_events();
      t_short();
      t_hold_reset();
      stop_test();
   end
endmodule : flsr_regs_tb
`default_nettype wire
